// *** src/eeprom_serial_dev.sv ***
`timescale 1ns/100ps

// Behaviour
// - Data changes only while clock low
// - Falling data, clock high, is start
// - Rising data, clock high, is stop
// - Acknowledge each received byte on ninth clock
// - Array access needs type nibble 1010
// - Select bits must match pins, else ignore
// - Lowest address bit selects read or write
// - Nibble 1011 reads serial block, never written
// - Two word-address bytes follow, each acknowledged
// - Byte write then stop starts timed write
// - Page write takes up to 32 bytes
// - Write increments low five bits, page wraps
// - No acknowledge until write cycle ends
// - Pointer holds last address plus one
// - Current read sends byte at pointer
// - Master acknowledge continues sequential read
// - Serial reads need address bits 10
// - Array and serial block share pointer
// - Serial region: 16 bytes, zeros, wrap
// - Standby at power-up and after stop
// - Write inhibit blocks array writes only
// - Sample on clock rise, drive after fall
// - Array is 128 pages of 32 bytes
module eeprom_serial_dev #(
   parameter logic [eeprom_link_pkg::WR_CNT_W-1:0] WRITE_CYCLES =
      eeprom_link_pkg::WR_CNT_W'(eeprom_link_pkg::INTERNAL_WRITE_CYCLES), // Write time
   parameter logic [127:0] SERIAL_NUMBER =
      128'h00112233445566778899aabbccddeeff  // Arbitrary value
) (
   input wire logic CORE_CLK,                    // Core clock, 40 MHz
   input wire logic RST,                         // Async reset, high
   input wire logic LINK_CLK,                    // Link sampling clock
   input wire logic SCL_IN,                      // Serial clock pin
   input wire logic SDA_IN,                      // Serial data pin level
   output logic SDA_OUT,                         // Data drive value, always 0
   output logic SDA_OE_N,                        // Low pulls data line low
   input wire logic SELECT_PIN_HIGH,             // Hard-wired select, top
   input wire logic SELECT_PIN_MID,              // Hard-wired select, middle
   input wire logic SELECT_PIN_LOW,              // Hard-wired select, bottom
   input wire logic WRITE_INHIBIT,               // High blocks array writes
   output logic STANDBY,                         // Idle and no write running
   output logic WRITE_BUSY                       // Timed write in progress
);

   localparam int AW = eeprom_link_pkg::ADDR_W;
   localparam int PW = eeprom_link_pkg::PAGE_W;

   // Link domain signals
   logic [5:0] pins;                             // Synchronised pin levels
   logic scl;                                    // Clock pin, synchronised
   logic sda;                                    // Data pin, synchronised
   logic [2:0] select_pins;                      // Select straps
   logic inhibit;                                // Write inhibit level
   logic scl_d;                                  // Clock, one cycle late
   logic sda_d;                                  // Data, one cycle late
   logic scl_rise;                               // Clock rising edge
   logic scl_fall;                               // Clock falling edge
   logic start_det;                              // Start seen
   logic stop_det;                               // Stop seen
   eeprom_link_pkg::link_state_e state;          // Engine state
   eeprom_link_pkg::rx_phase_e phase;            // Byte being received
   logic [3:0] bit_cnt;                          // Bits in current byte
   logic [7:0] rx_sh;                            // Receive shifter
   logic [7:0] tx_sh;                            // Transmit shifter
   logic [AW-1:0] ptr;                           // Shared address pointer
   logic [AW-1:0] next_ptr;                      // Pointer after a read
   logic serial;                                 // Serial block selected
   logic rd;                                     // Read direction latched
   logic master_ack;                             // Master acked last byte
   logic [31:0] mask;                            // Page latch bytes loaded
   logic [PW-1:0] commit_idx;                    // Page latch copy index
   logic req_tgl;                                // Write cycle request
   logic ack_link;                               // Write done, synchronised
   logic busy;                                   // Write still under way
   logic byte_done;                              // Ninth-clock decision point
   logic dev_match;                              // Address word is ours
   logic buf_we;                                 // Page latch write strobe
   logic [7:0] rd_byte;                          // Byte to send next
   logic [7:0] sn_byte;                          // Serial number byte
   logic [7:0] mem [eeprom_link_pkg::ARRAY_BYTES]; // Array store
   logic [7:0] page_buf [eeprom_link_pkg::PAGE_BYTES]; // Page latch

   // Core domain signals
   logic req_core;                               // Request, synchronised
   logic req_seen;                               // Last request served
   logic ack_tgl;                                // Done toggle to link
   logic [eeprom_link_pkg::WR_CNT_W-1:0] wr_cnt; // Write time remaining

   // Pins pass two flops before use
   pin_sync #(
      .W(6),
      .RESET_VAL(6'h3f)
   ) u_pin_sync (
      .clk(LINK_CLK),
      .rst(RST),
      .d({SCL_IN, SDA_IN, SELECT_PIN_HIGH, SELECT_PIN_MID, SELECT_PIN_LOW,
          WRITE_INHIBIT}),
      .q(pins)
   );

   // Write done toggle into the link domain
   pin_sync #(
      .W(1),
      .RESET_VAL(1'b0)
   ) u_ack_sync (
      .clk(LINK_CLK),
      .rst(RST),
      .d(ack_tgl),
      .q(ack_link)
   );

   // Write request toggle into the core domain
   pin_sync #(
      .W(1),
      .RESET_VAL(1'b0)
   ) u_req_sync (
      .clk(CORE_CLK),
      .rst(RST),
      .d(req_tgl),
      .q(req_core)
   );

   assign scl = pins[5];
   assign sda = pins[4];
   assign select_pins = pins[3:1];
   assign inhibit = pins[0];

   // Delayed copies for edge detection
   always_ff @(posedge LINK_CLK or posedge RST) begin
      if (RST) begin
         scl_d <= eeprom_link_pkg::PIN_IDLE;
         sda_d <= eeprom_link_pkg::PIN_IDLE;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
      end
   end

   // Edge and condition decode
   assign scl_rise = scl && !scl_d;
   assign scl_fall = !scl && scl_d;
   assign start_det = scl && scl_d && sda_d && !sda;
   assign stop_det = scl && scl_d && !sda_d && sda;
   assign busy = (req_tgl != ack_link) || (state == eeprom_link_pkg::ST_COMMIT);
   assign byte_done = (state == eeprom_link_pkg::ST_RX) && scl_fall
      && (bit_cnt == 4'(eeprom_link_pkg::BITS_PER_WORD));

   // Address word check against type nibble and straps
   assign dev_match =
      ((rx_sh[eeprom_link_pkg::DEV_TYPE_MSB:eeprom_link_pkg::DEV_TYPE_LSB]
        == eeprom_link_pkg::DEV_ARRAY)
       || (rx_sh[eeprom_link_pkg::DEV_TYPE_MSB:eeprom_link_pkg::DEV_TYPE_LSB]
        == eeprom_link_pkg::DEV_SERIAL))
      && (rx_sh[eeprom_link_pkg::DEV_SEL_MSB:eeprom_link_pkg::DEV_SEL_LSB]
        == select_pins);

   // Data byte lands in the page latch only for array, not inhibited
   assign buf_we = byte_done && (phase == eeprom_link_pkg::PH_DATA)
      && !serial && !inhibit;

   // Serial byte, first byte is the most significant
   assign sn_byte = SERIAL_NUMBER[{~ptr[3:0], 3'h0} +: 8];

   // Byte selection for the next read
   always_comb begin
      if (!serial) begin
         rd_byte = mem[ptr];
      end else if (ptr[AW-1:AW-2] != eeprom_link_pkg::SN_AREA) begin
         rd_byte = eeprom_link_pkg::UNDEF_BYTE;
      end else if (ptr[4]) begin
         rd_byte = eeprom_link_pkg::SN_FILL;
      end else begin
         rd_byte = sn_byte;
      end
   end

   // Pointer after a read: array wraps whole, serial wraps in 32
   always_comb begin
      if (serial) begin
         next_ptr = {ptr[AW-1:PW], ptr[PW-1:0] + 5'h1};
      end else begin
         next_ptr = ptr + 12'h001;
      end
   end

   // Protocol engine
   always_ff @(posedge LINK_CLK or posedge RST) begin
      if (RST) begin
         state <= eeprom_link_pkg::ST_IDLE;
         phase <= eeprom_link_pkg::PH_DEV;
         bit_cnt <= 4'h0;
         rx_sh <= 8'h00;
         tx_sh <= 8'h00;
         ptr <= eeprom_link_pkg::PTR_RST;
         serial <= 1'b0;
         rd <= 1'b0;
         master_ack <= 1'b0;
         mask <= 32'h00000000;
         commit_idx <= 5'h00;
         req_tgl <= 1'b0;
         SDA_OE_N <= 1'b1;
      end else if (start_det && state != eeprom_link_pkg::ST_COMMIT) begin
         // A start outside ST_COMMIT restarts command decode
         state <= eeprom_link_pkg::ST_RX;
         phase <= eeprom_link_pkg::PH_DEV;
         bit_cnt <= 4'h0;
         mask <= 32'h00000000;
         SDA_OE_N <= 1'b1;
      end else if (stop_det && state != eeprom_link_pkg::ST_COMMIT) begin
         // Stop commits loaded bytes, else back to standby
         SDA_OE_N <= 1'b1;
         commit_idx <= 5'h00;
         if (|mask) begin
            state <= eeprom_link_pkg::ST_COMMIT;
         end else begin
            state <= eeprom_link_pkg::ST_IDLE;
         end
      end else begin
         case (state)
            eeprom_link_pkg::ST_RX: begin
               if (scl_rise) begin
                  // Sample on rising clock
                  rx_sh <= {rx_sh[6:0], sda};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (byte_done) begin
                  bit_cnt <= 4'h0;
                  case (phase)
                     eeprom_link_pkg::PH_DEV: begin
                        if (dev_match && !busy) begin
                           SDA_OE_N <= 1'b0;
                           state <= eeprom_link_pkg::ST_ACK;
                           rd <= rx_sh[eeprom_link_pkg::DEV_RW_BIT];
                           serial <= rx_sh[eeprom_link_pkg::DEV_TYPE_LSB];
                        end else begin
                           state <= eeprom_link_pkg::ST_IDLE;
                        end
                     end
                     eeprom_link_pkg::PH_ADDR_HI: begin
                        ptr[AW-1:8] <= rx_sh[3:0];
                        SDA_OE_N <= 1'b0;
                        state <= eeprom_link_pkg::ST_ACK;
                     end
                     eeprom_link_pkg::PH_ADDR_LO: begin
                        ptr[7:0] <= rx_sh;
                        SDA_OE_N <= 1'b0;
                        state <= eeprom_link_pkg::ST_ACK;
                     end
                     default: begin
                        // Data byte, page offset wraps
                        if (buf_we) begin
                           mask[ptr[PW-1:0]] <= 1'b1;
                        end
                        ptr[PW-1:0] <= ptr[PW-1:0] + 5'h1;
                        SDA_OE_N <= 1'b0;
                        state <= eeprom_link_pkg::ST_ACK;
                     end
                  endcase
               end
            end
            eeprom_link_pkg::ST_ACK: begin
               if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  if (phase == eeprom_link_pkg::PH_DEV && rd) begin
                     // Read: first bit goes out on this fall
                     tx_sh <= rd_byte;
                     SDA_OE_N <= rd_byte[7];
                     ptr <= next_ptr;
                     state <= eeprom_link_pkg::ST_TX;
                  end else begin
                     SDA_OE_N <= 1'b1;
                     state <= eeprom_link_pkg::ST_RX;
                     case (phase)
                        eeprom_link_pkg::PH_DEV: phase <= eeprom_link_pkg::PH_ADDR_HI;
                        eeprom_link_pkg::PH_ADDR_HI: phase <= eeprom_link_pkg::PH_ADDR_LO;
                        default: phase <= eeprom_link_pkg::PH_DATA;
                     endcase
                  end
               end
            end
            eeprom_link_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt == 4'h7) begin
                     SDA_OE_N <= 1'b1;                         // Free for master
                     state <= eeprom_link_pkg::ST_MACK;
                  end else begin
                     bit_cnt <= bit_cnt + 4'h1;
                     tx_sh <= {tx_sh[6:0], 1'b0};
                     SDA_OE_N <= tx_sh[6];
                  end
               end
            end
            eeprom_link_pkg::ST_MACK: begin
               if (scl_rise) begin
                  master_ack <= !sda;
               end else if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  if (master_ack) begin
                     // Acknowledged: send the following byte
                     tx_sh <= rd_byte;
                     SDA_OE_N <= rd_byte[7];
                     ptr <= next_ptr;
                     state <= eeprom_link_pkg::ST_TX;
                  end else begin
                     state <= eeprom_link_pkg::ST_IDLE;
                  end
               end
            end
            eeprom_link_pkg::ST_COMMIT: begin
               // One latch entry per cycle, then timed write
               commit_idx <= commit_idx + 5'h1;
               if (commit_idx == 5'h1f) begin
                  mask <= 32'h00000000;
                  req_tgl <= ~req_tgl;
                  state <= eeprom_link_pkg::ST_IDLE;
               end
            end
            default: begin
               SDA_OE_N <= 1'b1;
            end
         endcase
      end
   end

   // Page latch load
   always_ff @(posedge LINK_CLK) begin
      if (buf_we) begin
         page_buf[ptr[PW-1:0]] <= rx_sh;
      end
   end

   // Array update from the latch, same page row kept
   always_ff @(posedge LINK_CLK) begin
      if (state == eeprom_link_pkg::ST_COMMIT && mask[commit_idx]) begin
         mem[{ptr[AW-1:PW], commit_idx}] <= page_buf[commit_idx];
      end
   end

   // Open-drain value and standby flag
   always_ff @(posedge LINK_CLK or posedge RST) begin
      if (RST) begin
         SDA_OUT <= 1'b0;
         STANDBY <= 1'b1;
      end else begin
         SDA_OUT <= 1'b0;
         STANDBY <= (state == eeprom_link_pkg::ST_IDLE) && !busy;
      end
   end

   // Self-timed write cycle in the core domain
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         req_seen <= 1'b0;
         ack_tgl <= 1'b0;
         wr_cnt <= '0;
         WRITE_BUSY <= 1'b0;
      end else if (req_core != req_seen) begin
         req_seen <= req_core;
         wr_cnt <= WRITE_CYCLES;
         WRITE_BUSY <= 1'b1;
      end else if (wr_cnt > 18'h00001) begin
         wr_cnt <= wr_cnt - 18'h00001;
      end else if (WRITE_BUSY) begin
         wr_cnt <= '0;
         WRITE_BUSY <= 1'b0;
         ack_tgl <= req_seen;
      end
   end

endmodule

// *** src/eeprom_link_pkg.sv ***
package eeprom_link_pkg;

   // Protocol engine states
   typedef enum logic [2:0] {
      ST_IDLE,     // Released, waiting for a start
      ST_RX,       // Shifting in a byte from the master
      ST_ACK,      // Holding the line low for our acknowledge
      ST_TX,       // Shifting out a read byte
      ST_MACK,     // Ninth clock of a read, master answers
      ST_COMMIT    // Copying the page latch into the array
   } link_state_e;

   // Which byte of a command is being received
   typedef enum logic [1:0] {
      PH_DEV,      // Device address word
      PH_ADDR_HI,  // Word address, upper part
      PH_ADDR_LO,  // Word address, lower byte
      PH_DATA      // Write data
   } rx_phase_e;

   // Array geometry
   localparam int ADDR_W = 12;                   // Word address width
   localparam int PAGE_W = 5;                    // Offset bits inside a page
   localparam int PAGE_BYTES = 32;               // Bytes per page
   localparam int ARRAY_BYTES = 4096;            // 128 pages of 32 bytes
   localparam int BITS_PER_WORD = 8;             // Serial word length

   // Device address word layout
   localparam logic [3:0] DEV_ARRAY = 4'ha;      // Upper nibble, array access
   localparam logic [3:0] DEV_SERIAL = 4'hb;     // Upper nibble, serial block
   localparam int DEV_TYPE_MSB = 7;              // Type nibble top bit
   localparam int DEV_TYPE_LSB = 4;              // Type nibble low bit
   localparam int DEV_SEL_MSB = 3;               // Select field top bit
   localparam int DEV_SEL_LSB = 1;               // Select field low bit
   localparam int DEV_RW_BIT = 0;                // Direction bit, 1 reads

   // Serial number region
   localparam logic [1:0] SN_AREA = 2'b10;       // Word address bits 11:10
   localparam int SN_BYTES = 16;                 // Bytes of serial number
   localparam logic [7:0] SN_FILL = 8'h00;       // Upper half of the region
   localparam logic [7:0] UNDEF_BYTE = 8'hff;    // Answer for a bad region

   // Timing
   localparam int CORE_CLK_PERIOD_NS = 25;                 // 40 MHz
   localparam int INTERNAL_WRITE_TIME_MS = 5;              // Longest write
   localparam int INTERNAL_WRITE_CYCLES =
      (INTERNAL_WRITE_TIME_MS * 1000000) / CORE_CLK_PERIOD_NS;
   localparam int WR_CNT_W = 18;                           // Timer width

   // Reset values
   localparam logic PIN_IDLE = 1'b1;             // Bus lines idle high
   localparam logic [2:0] BIT_CNT_RST = 3'h0;    // Bit counter at reset
   localparam logic [ADDR_W-1:0] PTR_RST = 12'h000; // Pointer at power-up

endpackage

// *** src/pin_sync.sv ***
`timescale 1ns/100ps

module pin_sync #(
   parameter int W = 1,                          // Number of lines
   parameter logic [W-1:0] RESET_VAL = '0        // Value held in reset
) (
   input wire logic clk,                         // Destination clock
   input wire logic rst,                         // Async reset, high
   input wire logic [W-1:0] d,                   // Foreign-domain input
   output logic [W-1:0] q                        // Synchronised copy
);

   logic [W-1:0] meta;                           // First stage, only q reads it

   // Two-stage synchroniser
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule

// *** verification/eeprom_serial_dev_asserts.sv ***
`timescale 1ns/100ps
module eeprom_serial_dev_asserts (
   input wire logic LINK_CLK, // Link clock
   input wire logic RST, // Async reset
   input wire logic SCL_IN, // Clock pin
   input wire logic SDA_OUT, // Drive value
   input wire logic SDA_OE_N, // Low pulls data low
   input wire logic STANDBY, // Idle flag
   input wire logic WRITE_BUSY // Timed write
);
   // Everything is judged in the link domain
   default clocking cb @(posedge LINK_CLK);
   endclocking
   default disable iff (RST);
   drive_zero_a: assert property (SDA_OUT == 1'b0)
      else $error("data drive value not zero");
   oe_scl_low_a: assert property ($changed(SDA_OE_N) |-> !SCL_IN)
      else $error("data drive changed with clock high");
   ack_hold_a: assert property ($fell(SDA_OE_N) |=> !SDA_OE_N [*8])
      else $error("low drive too short");
   busy_no_ack_a: assert property (WRITE_BUSY |-> SDA_OE_N)
      else $error("drive during timed write");
   busy_not_idle_a: assert property (WRITE_BUSY |-> !STANDBY)
      else $error("standby during timed write");
   idle_released_a: assert property (STANDBY |-> SDA_OE_N)
      else $error("drive while idle");
   wake_on_start_a: assert property ($fell(STANDBY) |-> SCL_IN)
      else $error("woke without start");
   busy_span_a: assert property ($rose(WRITE_BUSY) |=> WRITE_BUSY [*8])
      else $error("timed write too short");
   cover property ($fell(SDA_OE_N));
   cover property ($rose(WRITE_BUSY));
   cover property ($rose(STANDBY));
endmodule

// *** verification/i2c_master_model.sv ***
`timescale 1ns/100ps
module i2c_master_model (
   input wire logic clk, // Core clock
   input wire logic sda, // Resolved data wire
   output logic scl, // Serial clock drive
   output logic sda_m // Data drive, 1 releases
);
   // Bus idles high, clock still
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // Third of a serial clock period
   task automatic t;
      repeat (2) @(negedge clk);
   endtask
   // Falling data with clock high
   task automatic start;
      sda_m = 1'b1;
      t;
      scl = 1'b1;
      t;
      sda_m = 1'b0;
      t;
      scl = 1'b0;
      t;
   endtask
   // Rising data with clock high
   task automatic stop;
      sda_m = 1'b0;
      t;
      scl = 1'b1;
      t;
      sda_m = 1'b1;
      t;
   endtask
   // One clock; data set while clock low
   task automatic bit_io(input logic b, output logic r);
      sda_m = b;
      t;
      scl = 1'b1;
      t;
      r = sda;
      scl = 1'b0;
      t;
   endtask
   // Eight bits out, ninth bit answer
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(last, r);
      ack = !r;
   endtask
   // Start, nine clocks, start, stop
   task automatic recover;
      logic r;
      start;
      repeat (9) bit_io(1'b1, r);
      start;
      stop;
   endtask
endmodule

// *** verification/i2c_eeprom_serial_number_tb.sv ***
`timescale 1ns/100ps
module i2c_eeprom_serial_number_tb;
   localparam logic [127:0] SN = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0; // Arbitrary value
   localparam logic [3:0] A = eeprom_link_pkg::DEV_ARRAY; // Array type
   localparam logic [3:0] S = eeprom_link_pkg::DEV_SERIAL; // Serial type
   logic core_clk = 1'b0; // Core clock
   logic link_clk = 1'b0; // Link clock
   logic rst = 1'b1; // Reset
   logic wi = 1'b0; // Write inhibit
   logic [2:0] sel = 3'h0; // Straps
   logic [7:0] seed = 8'h49; // Random state
   logic sda_out, sda_oe_n, standby, busy, scl, sda_m, a, r; // Lines
   logic [7:0] q; // Last byte
   logic [7:0] mem [logic [11:0]]; // Expected array
   logic [11:0] ptr; // Expected pointer
   int checks, miscompares, cycles; // Counters
   wire sda = sda_m & (sda_oe_n | sda_out); // Pulled-up wire
   always #12.5 core_clk = ~core_clk;
   always #3 link_clk = ~link_clk;
   eeprom_serial_dev #(.WRITE_CYCLES(18'h190), .SERIAL_NUMBER(SN)) eeprom_serial_dev_i (
      .CORE_CLK(core_clk), .RST(rst), .LINK_CLK(link_clk), .SCL_IN(scl), .SDA_IN(sda),
      .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .SELECT_PIN_HIGH(sel[2]),
      .SELECT_PIN_MID(sel[1]), .SELECT_PIN_LOW(sel[0]), .WRITE_INHIBIT(wi),
      .STANDBY(standby), .WRITE_BUSY(busy));
   i2c_master_model i2c_master_model_i (.clk(core_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
   function automatic logic [7:0] lfsr(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [7:0] dw(logic [3:0] ty, logic rd);
      return {ty, sel, rd};
   endfunction
   // Next expected read byte
   function automatic logic [7:0] model_rd(logic [3:0] ty);
      logic [7:0] v;
      if (ty == S) begin
         v = ptr[4] ? 8'h00 : SN[127 - 8 * ptr[3:0] -: 8];
         ptr = {ptr[11:5], ptr[4:0] + 5'h1};
      end else begin
         v = mem[ptr];
         ptr = ptr + 12'h1;
      end
      return v;
   endfunction
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic send(logic [7:0] d);
      i2c_master_model_i.xfer(d, 1'b1, q, a);
      chk("ack", 8'h1, {7'h0, a});
   endtask
   task automatic head(logic [3:0] ty, logic [15:0] ad);
      i2c_master_model_i.start;
      send(dw(ty, 1'b0));
      send(ad[15:8]);
      send(ad[7:0]);
   endtask
   // Write n random bytes, then poll until ready
   task automatic wr(logic [15:0] ad, int n);
      logic [4:0] off;
      off = ad[4:0];
      head(A, ad);
      repeat (n) begin
         seed = lfsr(seed);
         send(seed);
         if (!wi)
            mem[{ad[11:5], off}] = seed;
         off++;
      end
      i2c_master_model_i.stop;
      // Timed write runs only when bytes were stored
      repeat (20) @(negedge core_clk);
      chk("busy", {7'h0, !wi}, {7'h0, busy});
      chk("standby", {7'h0, wi}, {7'h0, standby});
      for (int i = 0; i < 30 && (i == 0 || !a); i++) begin
         i2c_master_model_i.start;
         i2c_master_model_i.xfer(dw(A, 1'b1), 1'b1, q, a);
         if (i == 0 && !wi)
            chk("poll ack", 8'h0, {7'h0, a});
      end
      chk("poll done", 8'h1, {7'h0, a});
      i2c_master_model_i.xfer(8'hff, 1'b1, q, r);
      i2c_master_model_i.stop;
      $display("test write %h done", ad);
   endtask
   task automatic rd(logic [3:0] ty, logic [15:0] ad, int n, logic dum);
      if (dum) begin
         head(ty, ad);
         ptr = ad[11:0];
      end
      i2c_master_model_i.start;
      send(dw(ty, 1'b1));
      for (int i = 0; i < n; i++) begin
         i2c_master_model_i.xfer(8'hff, i == n - 1, q, a);
         chk("read data", model_rd(ty), q);
      end
      i2c_master_model_i.stop;
      $display("test read %h done", ad);
   endtask
   task automatic complete_run;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         complete_run;
      end
   end
   // Main sequence
   initial begin
      seed = lfsr(seed);
      sel = seed[2:0];
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      chk("standby", 8'h1, {7'h0, standby});
      chk("busy", 8'h0, {7'h0, busy});
      wr(16'h007e, 4);
      rd(A, 16'h0060, 2, 1'b1);
      rd(A, 16'h007e, 2, 1'b1);
      rd(A, 16'h0060, 1, 1'b1);
      rd(A, 16'h0000, 1, 1'b0);
      wi = 1'b1;
      wr(16'h0061, 1);
      wi = 1'b0;
      rd(A, 16'h0061, 1, 1'b1);
      wr(16'h0fff, 1);
      wr(16'h0000, 1);
      rd(A, 16'h0fff, 2, 1'b1);
      for (int i = 0; i < 2; i++) begin
         i2c_master_model_i.start;
         i2c_master_model_i.xfer(i ? {4'hc, sel, 1'b0} : {A, ~sel, 1'b0}, 1'b1, q, a);
         chk("bad address ack", 8'h0, {7'h0, a});
         i2c_master_model_i.xfer(8'h00, 1'b1, q, a);
         chk("unselected ack", 8'h0, {7'h0, a});
         i2c_master_model_i.stop;
      end
      $display("test bad address done");
      rd(S, 16'h0800, 33, 1'b1);
      // Data sent to the serial block must not land
      head(S, 16'h0800);
      send(8'h5a);
      i2c_master_model_i.stop;
      rd(S, 16'h0800, 1, 1'b1);
      i2c_master_model_i.start;
      repeat (4) i2c_master_model_i.bit_io(1'b1, r);
      i2c_master_model_i.recover;
      rd(A, 16'h007f, 1, 1'b1);
      // Reset in mid-run: pointer back to zero, array kept
      rst = 1'b1;
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      chk("standby", 8'h1, {7'h0, standby});
      ptr = 12'h000;
      rd(A, 16'h0000, 1, 1'b0);
      complete_run;
   end
endmodule
bind eeprom_serial_dev eeprom_serial_dev_asserts eeprom_serial_dev_asserts_i (
   .LINK_CLK, .RST, .SCL_IN, .SDA_OUT, .SDA_OE_N, .STANDBY, .WRITE_BUSY);
